// File: alu_ops_pkg.sv
// Constants and carrier types for the immediate and bit-operation datapath.
// Assumes one core clock; all files compile after this package.
package alu_ops_pkg;

  localparam int DATA_W   = 8;
  localparam int ADDR_W   = 6;
  localparam int BIT_W    = 3;
  localparam int REG_DEPTH = 64;
  localparam int NIBBLE_MSB = 3;
  localparam logic [7:0] ACC_RESET  = 8'h00;
  localparam logic       FLAG_RESET = 1'b0;
  localparam int OP_CYCLES = 1;

  // Operation selector, one-hot
  typedef enum logic [6:0] {
    OP_NONE       = 7'h01,
    OP_ADD_IMM_C  = 7'h02,
    OP_ADD_IMM    = 7'h04,
    OP_AND_REG    = 7'h08,
    OP_AND_IMM    = 7'h10,
    OP_BIT_CLEAR  = 7'h20,
    OP_BIT_SET    = 7'h40
  } op_e;

  // One issued instruction
  typedef struct packed {
    op_e               op;
    logic [7:0]        imm;
    logic [5:0]        addr;
    logic [2:0]        bitSel;
    logic              destReg;
  } instr_s;

  // Status flags
  typedef struct packed {
    logic zero;
    logic halfCarry;
    logic carry;
  } flags_s;

endpackage : alu_ops_pkg

// File: reg_file_mem.sv
// Register file of 64 bytes with registered read data.
// Assumes write and read addresses come from the same core clock domain.
`timescale 1ns/1ns
module reg_file_mem (
  input  wire logic                         clk,
  input  wire logic                         clkEn,
  input  wire logic [alu_ops_pkg::ADDR_W-1:0] rdAddr,
  output logic      [alu_ops_pkg::DATA_W-1:0] rdData,
  input  wire logic                         wrEn,
  input  wire logic [alu_ops_pkg::ADDR_W-1:0] wrAddr,
  input  wire logic [alu_ops_pkg::DATA_W-1:0] wrData
);
  import alu_ops_pkg::*;

  logic [DATA_W-1:0] mem [REG_DEPTH];

  // Storage has no reset; contents are software defined
  always_ff @(posedge clk) begin
    if (clkEn) begin
      if (wrEn) begin
        mem[wrAddr] <= wrData;
      end
      rdData <= mem[rdAddr];
    end
  end

endmodule : reg_file_mem

// File: immediate_bit_alu.sv
// Execution datapath: add immediate, AND, bit clear and bit set.
// Assumes the decoder holds rdAddr one cycle ahead so that the register
// operand is ready when the instruction issues (instrValid).
`timescale 1ns/1ns
module immediate_bit_alu (
  input  wire logic                          clk,
  input  wire logic                          rst_b,
  input  wire logic                          clkEn,
  input  wire logic                          instrValid,
  input  wire alu_ops_pkg::instr_s           instr,
  input  wire logic [alu_ops_pkg::ADDR_W-1:0] rdAddr,
  output logic      [alu_ops_pkg::DATA_W-1:0] working_accumulator,
  output alu_ops_pkg::flags_s                flags,
  output logic      [alu_ops_pkg::DATA_W-1:0] regRdData
);
  import alu_ops_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Nine-bit sum plus nibble carry
  function automatic logic [9:0] add8(input logic [7:0] a,
                                      input logic [7:0] b,
                                      input logic       cin);
    logic [4:0] lo;
    logic [8:0] full;
    lo   = {1'b0, a[NIBBLE_MSB:0]} + {1'b0, b[NIBBLE_MSB:0]} + {4'h0, cin};
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    return {lo[4], full};
  endfunction : add8

  // Single-bit mask from the bit number
  function automatic logic [7:0] bitMask(input logic [2:0] n);
    return 8'h01 << n;
  endfunction : bitMask

  ////////////////////////////////////////////////////////////////////////
  // Register file

  logic              memWrEn;
  logic [DATA_W-1:0] memWrData;
  logic [DATA_W-1:0] regOperand;

  reg_file_mem uMem (
    .clk    (clk),
    .clkEn  (clkEn),
    .rdAddr (rdAddr),
    .rdData (regOperand),
    .wrEn   (memWrEn),
    .wrAddr (instr.addr),
    .wrData (memWrData)
  );

  assign regRdData = regOperand;

  ////////////////////////////////////////////////////////////////////////
  // Next accumulator, flags and register write

  logic [DATA_W-1:0] acc_q, acc_d;
  flags_s            flags_q, flags_d;
  logic [9:0]        sum;
  logic [DATA_W-1:0] andRes;

  always_comb begin
    acc_d     = acc_q;
    flags_d   = flags_q;
    memWrEn   = 1'b0;
    memWrData = regOperand;
    sum       = 10'h000;
    andRes    = 8'h00;
    if (instrValid) begin
      case (instr.op)
        OP_ADD_IMM_C: begin
          sum             = add8(acc_q, instr.imm, flags_q.carry);
          acc_d           = sum[7:0];
          flags_d.carry   = sum[8];
          flags_d.halfCarry = sum[9];
          flags_d.zero    = (sum[7:0] == 8'h00);
        end
        OP_ADD_IMM: begin
          sum             = add8(acc_q, instr.imm, 1'b0);
          acc_d           = sum[7:0];
          flags_d.carry   = sum[8];
          flags_d.halfCarry = sum[9];
          flags_d.zero    = (sum[7:0] == 8'h00);
        end
        OP_AND_REG: begin
          andRes       = acc_q & regOperand;
          flags_d.zero = (andRes == 8'h00);
          if (instr.destReg) begin
            memWrEn   = 1'b1;
            memWrData = andRes;
          end else begin
            acc_d = andRes;
          end
        end
        OP_AND_IMM: begin
          andRes       = acc_q & instr.imm;
          acc_d        = andRes;
          flags_d.zero = (andRes == 8'h00);
        end
        OP_BIT_CLEAR: begin
          memWrEn   = 1'b1;
          memWrData = regOperand & ~bitMask(instr.bitSel);
        end
        OP_BIT_SET: begin
          memWrEn   = 1'b1;
          memWrData = regOperand | bitMask(instr.bitSel);
        end
        default: begin
          acc_d = acc_q;
        end
      endcase
    end
  end

  // State registers; clock enable freezes everything
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_q   <= ACC_RESET;
      flags_q <= '{FLAG_RESET, FLAG_RESET, FLAG_RESET};
    end else if (clkEn) begin
      acc_q   <= acc_d;
      flags_q <= flags_d;
    end
  end

  assign working_accumulator = acc_q;
  assign flags               = flags_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  logic isAdd;
  assign isAdd = instrValid &&
                 (instr.op == OP_ADD_IMM_C || instr.op == OP_ADD_IMM);

  a_add_carry_sum: assert property (@(posedge clk) disable iff (!rst_b)
    clkEn && instrValid && instr.op == OP_ADD_IMM_C |=>
      acc_q == 8'(($past(acc_q) + $past(instr.imm)) + 8'($past(flags_q.carry))))
    else $error("add with carry result wrong");

  a_add_plain_sum: assert property (@(posedge clk) disable iff (!rst_b)
    clkEn && instrValid && instr.op == OP_ADD_IMM |=>
      acc_q == 8'($past(acc_q) + $past(instr.imm)))
    else $error("add immediate result wrong");

  a_and_reg_flags: assert property (@(posedge clk) disable iff (!rst_b)
    clkEn && instrValid && instr.op == OP_AND_REG |=>
      $stable(flags_q.carry) && $stable(flags_q.halfCarry))
    else $error("register AND touched carry flags");

  a_and_reg_dest: assert property (@(posedge clk) disable iff (!rst_b)
    instrValid && instr.op == OP_AND_REG |->
      memWrEn == instr.destReg)
    else $error("register AND destination wrong");

  a_and_imm_res: assert property (@(posedge clk) disable iff (!rst_b)
    clkEn && instrValid && instr.op == OP_AND_IMM |=>
      acc_q == ($past(acc_q) & $past(instr.imm)) &&
      flags_q.zero == (acc_q == 8'h00))
    else $error("AND immediate result wrong");

  a_bit_clear: assert property (@(posedge clk) disable iff (!rst_b)
    clkEn && instrValid && instr.op == OP_BIT_CLEAR |->
      memWrEn && !memWrData[instr.bitSel] &&
      ((memWrData | bitMask(instr.bitSel)) ==
       (regOperand | bitMask(instr.bitSel)))
      ##1 ($stable(flags_q) && $stable(acc_q)))
    else $error("bit clear misbehaved");

  a_bit_set: assert property (@(posedge clk) disable iff (!rst_b)
    clkEn && instrValid && instr.op == OP_BIT_SET |->
      memWrEn && (memWrData == (regOperand | bitMask(instr.bitSel)))
      ##1 ($stable(flags_q) && $stable(acc_q)))
    else $error("bit set misbehaved");

  a_carry_out: assert property (@(posedge clk) disable iff (!rst_b)
    clkEn && isAdd |=>
      flags_q.carry == ((9'($past(acc_q)) + 9'($past(instr.imm)) +
        9'($past(instr.op) == OP_ADD_IMM_C && $past(flags_q.carry))) > 9'h0FF))
    else $error("carry flag wrong");

  a_zero_half: assert property (@(posedge clk) disable iff (!rst_b)
    clkEn && isAdd |=> flags_q.zero == (acc_q == 8'h00) &&
      flags_q.halfCarry == ((5'($past(acc_q[3:0])) + 5'($past(instr.imm[3:0]))
        + 5'($past(instr.op) == OP_ADD_IMM_C && $past(flags_q.carry)))
        > 5'h0F))
    else $error("zero or half carry flag wrong");

endmodule : immediate_bit_alu

// File: decoder_model.sv
// Decoder stand-in: read address first, then one instruction.
// Assumes the core clock and drives 1 ns after each rising edge.
`timescale 1ns/1ns
module decoder_model (
  input  wire logic                      clk,
  output logic                           clkEn,
  output logic                           instrValid,
  output alu_ops_pkg::instr_s            instr,
  output logic [alu_ops_pkg::ADDR_W-1:0] rdAddr
);
  import alu_ops_pkg::*;
  ////////////////////////////////////////////////////////////////////
  // Idle fields flip so stale values cannot pass as live ones
  initial begin
    clkEn = 1'b1;
    instrValid = 1'b0;
    instr = '{OP_NONE, 8'hA5, 6'h2A, 3'h5, 1'b0};
    rdAddr = 6'h00;
  end
  // Operand read is registered, so the address leads by one cycle
  task automatic issue(input instr_s i);
    @(posedge clk);
    #1 rdAddr = i.addr;
    @(posedge clk);
    #1 instr = i;
    instrValid = 1'b1;
    @(posedge clk);
    #1 instrValid = 1'b0;
    instr = '{OP_NONE, ~i.imm, ~i.addr, ~i.bitSel, ~i.destReg};
  endtask : issue
  // Clock enable changes just after an edge, like every other input
  task automatic enable(input logic en);
    @(posedge clk);
    #1 clkEn = en;
  endtask : enable
  // Readback after the write edge
  task automatic point(input logic [5:0] a);
    @(posedge clk);
    #1 rdAddr = a;
    repeat (2) @(posedge clk);
    #1;
  endtask : point
endmodule : decoder_model

// File: immediate_bit_alu_bench.sv
// Self-checking bench for the immediate and bit-operation datapath.
// Assumes the decoder stand-in in decoder_model.sv.
`timescale 1ns/1ns
module immediate_bit_alu_bench;
  import alu_ops_pkg::*;
  logic        clk, rst_b, clkEn, instrValid, live;
  instr_s      instr;
  logic [5:0]  rdAddr;
  logic [7:0]  acc, rdData, accM;
  flags_s      flags, flagsM;
  logic [7:0]  memM [REG_DEPTH];
  int          fails, checks_done;
  immediate_bit_alu dut (.clk(clk), .rst_b(rst_b), .clkEn(clkEn),
    .instrValid(instrValid), .instr(instr), .rdAddr(rdAddr),
    .working_accumulator(acc), .flags(flags), .regRdData(rdData));
  decoder_model dec (.clk(clk), .clkEn(clkEn), .instrValid(instrValid),
    .instr(instr), .rdAddr(rdAddr));
  ////////////////////////////////////////////////////////////////////
  // 100 MHz core clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [7:0] got, exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t %s got %h", $time, what, got);
    end
  endtask : check
  // Issue one op, update the reference, compare; live=0 means frozen
  task automatic run(input op_e op, input logic [7:0] imm,
                     input logic [5:0] a, input logic [2:0] b,
                     input logic d);
    logic [8:0] sum;
    logic [7:0] r;
    logic       cin;
    cin = (op == OP_ADD_IMM_C) ? flagsM.carry : 1'b0;
    sum = accM + imm + cin;
    r = accM & ((op == OP_AND_REG) ? memM[a] : imm);
    dec.issue('{op, imm, a, b, d});
    if (live) case (op)
      OP_ADD_IMM_C, OP_ADD_IMM: begin
        flagsM = '{sum[7:0] == 8'h00,
                   {1'b0, accM[3:0]} + imm[3:0] + cin > 5'h0F, sum[8]};
        accM = sum[7:0];
      end
      OP_AND_IMM, OP_AND_REG: begin
        flagsM.zero = (r == 8'h00);
        if (op == OP_AND_REG && d) memM[a] = r;
        else accM = r;
      end
      OP_BIT_CLEAR: memM[a][b] = 1'b0;
      OP_BIT_SET: memM[a][b] = 1'b1;
      default: ;
    endcase
    check(acc, accM, "acc");
    check({5'h00, flags}, {5'h00, flagsM}, "flags");
    if (op inside {OP_AND_REG, OP_BIT_CLEAR, OP_BIT_SET}) begin
      dec.point(a);
      check(rdData, memM[a], "reg");
    end
  endtask : run
  task automatic load(input logic [5:0] a, input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      run(v[i] ? OP_BIT_SET : OP_BIT_CLEAR, 8'h00, a, i[2:0], 1'b0);
    end
  endtask : load
  ////////////////////////////////////////////////////////////////////
  task automatic addTests();
    run(OP_ADD_IMM, 8'h12, 6'h01, 3'h0, 1'b0);
    run(OP_ADD_IMM_C, 8'h34, 6'h01, 3'h0, 1'b0);
    run(OP_ADD_IMM, 8'hBA, 6'h01, 3'h0, 1'b0);
    run(OP_ADD_IMM_C, 8'h0F, 6'h01, 3'h0, 1'b0);
    run(OP_ADD_IMM, 8'hFF, 6'h01, 3'h0, 1'b0);
    run(OP_ADD_IMM, 8'hF1, 6'h01, 3'h0, 1'b0);
    run(OP_ADD_IMM, 8'h12, 6'h01, 3'h0, 1'b0);
    run(OP_ADD_IMM, 8'hF0, 6'h01, 3'h0, 1'b0);
  endtask : addTests
  // Carry left set by the last add of addTests must survive the first AND; the 5A add then clears it
  task automatic andTests();
    run(OP_AND_IMM, 8'h00, 6'h01, 3'h0, 1'b0);
    run(OP_ADD_IMM, 8'h5A, 6'h01, 3'h0, 1'b0);
    run(OP_AND_IMM, 8'hAF, 6'h01, 3'h0, 1'b0);
    load(6'h3F, 8'h5A);
    run(OP_BIT_CLEAR, 8'h00, 6'h3F, 3'h3, 1'b0);
    load(6'h00, 8'hAF);
    run(OP_ADD_IMM, 8'h50, 6'h01, 3'h0, 1'b0);
    run(OP_AND_REG, 8'h00, 6'h00, 3'h0, 1'b1);
    run(OP_AND_REG, 8'h00, 6'h3F, 3'h0, 1'b0);
  endtask : andTests
  // Disabled clock and the empty opcode must leave state alone
  task automatic holdTests();
    dec.enable(1'b0);
    live = 1'b0;
    run(OP_ADD_IMM, 8'h11, 6'h01, 3'h0, 1'b0);
    run(OP_BIT_SET, 8'h00, 6'h3F, 3'h0, 1'b0);
    dec.enable(1'b1);
    live = 1'b1;
    run(OP_NONE, 8'h22, 6'h01, 3'h0, 1'b0);
    // A frozen bit set must not have reached the register file
    run(OP_AND_REG, 8'h00, 6'h3F, 3'h0, 1'b0);
  endtask : holdTests
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  initial begin
    rst_b = 1'b0;
    live = 1'b1;
    accM = 8'h00;
    flagsM = '0;
    repeat (16) @(posedge clk);
    #1 rst_b = 1'b1;
    check(acc, 8'h00, "reset acc");
    check({5'h00, flags}, 8'h00, "reset flags");
    addTests();
    andTests();
    holdTests();
    conclude();
  end
  // Run takes about 1860 ns; cut a hang well beyond that
  initial begin
    #30000;
    fails++;
    conclude();
  end
endmodule : immediate_bit_alu_bench
